// *** rtl/caf_defines.svh ***
/*
  Register indices, field positions and reset values of the CAN acceptance filter.
  Assumes inclusion by bare name from the filter module; the property checker and the bench decode with literal addresses.
*/
`ifndef CAF_DEFINES_SVH
`define CAF_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define CAF_IDX_CTRL 6'h00
`define CAF_IDX_STAT 6'h01
`define CAF_IDX_FILT 6'h02
`define CAF_IDX_MISC 6'h03
`define CAF_IDX_RXERR 6'h04
`define CAF_IDX_TXERR 6'h05
`define CAF_IDX_ISTAT 6'h06
`define CAF_IDX_IMASK 6'h07
`define CAF_IDX_FGID 6'h08
`define CAF_IDX_BGID 6'h09
`define CAF_IDX_CODE0 6'h10
`define CAF_IDX_CODE3 6'h13
`define CAF_IDX_MASK0 6'h14
`define CAF_IDX_MASK3 6'h17
`define CAF_IDX_CODE4 6'h18
`define CAF_IDX_CODE7 6'h1b
`define CAF_IDX_MASK4 6'h1c
`define CAF_IDX_MASK7 6'h1f

// Word address slice and the upper address bits that must be zero.
`define CAF_IDX_MSB 7
`define CAF_IDX_LSB 2
`define CAF_ADDR_HI_MSB 31
`define CAF_ADDR_HI_LSB 8

// Position of the filter-area flag, bank bit and mask-select bit in an index.
`define CAF_IDX_FILT_AREA 4
`define CAF_IDX_TOP 5
`define CAF_IDX_BANK 3
`define CAF_IDX_IS_MASK 2

// Control register fields.
`define CAF_CTRL_INIT_REQ 0
`define CAF_CTRL_SLEEP_REQ 1
`define CAF_CTRL_USER_RECOV 2
`define CAF_CTRL_W 3
`define CAF_CTRL_RST 3'h1

// Status register fields.
`define CAF_STAT_INIT_ACK 0
`define CAF_STAT_SLEEP_ACK 1
`define CAF_STAT_BUSOFF 2

// Filter organization and hit index fields.
`define CAF_FILT_ORG_MSB 5
`define CAF_FILT_ORG_LSB 4
`define CAF_FILT_HIT_MSB 2
`define CAF_FILT_HIT_LSB 0

// Bus-off hold flag position.
`define CAF_MISC_HOLD 0

// Interrupt status and mask fields.
`define CAF_INT_ACCEPT 0
`define CAF_INT_BUSOFF 1
`define CAF_INT_W 2
`define CAF_INT_RST 2'h0

// Reset values.
`define CAF_BYTE_RST 8'h00
`define CAF_WORD_RST 32'h0000_0000

`endif

// *** rtl/caf_pkg.sv ***
/*
  Types of the CAN acceptance filter: filter organization, bus slave states
  and the received message carrier.
  Assumes nothing of its surroundings.
*/
package caf_pkg;

  // Filter organization, in the order of its two-bit field encoding.
  typedef enum logic [1:0] {
    CAF_ORG_32,
    CAF_ORG_16,
    CAF_ORG_8,
    CAF_ORG_CLOSED
  } caf_org_t;

  // Data phase kind of the register bus slave.
  typedef enum logic [1:0] {
    CAF_BUS_IDLE,
    CAF_BUS_WRITE,
    CAF_BUS_READ
  } caf_bus_t;

  // A received message header: four identifier bytes, byte 0 first on the wire.
  typedef struct packed {
    logic [3:0][7:0] id_bytes;
    logic ext;
  } caf_rx_msg_t;

endpackage

// *** rtl/caf_filter.sv ***
/*
  CAN identifier acceptance filter with bus-off hold flag, error counter view,
  interrupt status and an AHB-Lite register slave.
  Assumes the protocol engine on the same clock delivers each received header
  with a one-cycle valid pulse, its bus-off level, both error counters and the
  init and sleep acknowledges; the one bus master owns hready.
*/
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`include "caf_defines.svh"

module caf_filter
  import caf_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_rx_valid,
  input wire caf_rx_msg_t i_rx_msg,
  input wire logic i_busoff,
  input wire logic [7:0] i_rx_err_cnt,
  input wire logic [7:0] i_tx_err_cnt,
  input wire logic i_init_ack,
  input wire logic i_sleep_ack,
  output logic o_init_request,
  output logic o_sleep_request,
  output logic o_busoff_hold,
  output logic o_recover_req,
  output logic o_rx_accept,
  output logic [2:0] o_filter_hit_index,
  output logic o_irq
);

  // One identifier byte against one code and mask byte.
  function automatic logic byte_match(input logic [7:0] code, input logic [7:0] mask,
                                      input logic [7:0] id);
    byte_match = &((~(code ^ id)) | mask);
  endfunction

  // Lowest numbered filter that matched.
  function automatic logic [2:0] first_hit(input logic [7:0] hits);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (hits[i])
      begin
        idx = 3'(i);
      end
    end
    first_hit = idx;
  endfunction

  logic [7:0] code_reg [0:7];
  logic [7:0] mask_reg [0:7];
  logic [`CAF_CTRL_W-1:0] ctrl_reg;
  caf_org_t org_reg;
  logic hold_reg;
  logic busoff_q_reg;
  logic [`CAF_INT_W-1:0] istat_reg;
  logic [`CAF_INT_W-1:0] imask_reg;
  logic [31:0] fg_id_reg;
  logic [31:0] bg_id_reg;
  caf_bus_t bus_reg;
  logic [5:0] idx_reg;
  logic addr_ok_reg;

  // Address phase acceptance and data phase decoding.
  wire logic take = i_hsel & i_htrans[1] & i_hready;
  wire logic addr_ok = (i_haddr[`CAF_ADDR_HI_MSB:`CAF_ADDR_HI_LSB] == '0);
  wire logic wr_en = (bus_reg == CAF_BUS_WRITE) & addr_ok_reg;
  wire logic init_mode = ctrl_reg[`CAF_CTRL_INIT_REQ] & i_init_ack;
  wire logic filt_area = idx_reg[`CAF_IDX_FILT_AREA] & ~idx_reg[`CAF_IDX_TOP];  // Upper indices stay unmapped.
  wire logic [2:0] slot = {idx_reg[`CAF_IDX_BANK], idx_reg[1:0]};
  wire logic filt_wr = wr_en & filt_area & init_mode;
  wire logic code_wr = filt_wr & ~idx_reg[`CAF_IDX_IS_MASK];
  wire logic mask_wr = filt_wr & idx_reg[`CAF_IDX_IS_MASK];
  wire logic ctrl_wr = wr_en & (idx_reg == `CAF_IDX_CTRL);
  wire logic org_wr = wr_en & (idx_reg == `CAF_IDX_FILT) & init_mode;
  wire logic misc_wr = wr_en & (idx_reg == `CAF_IDX_MISC);
  wire logic istat_wr = wr_en & (idx_reg == `CAF_IDX_ISTAT);
  wire logic imask_wr = wr_en & (idx_reg == `CAF_IDX_IMASK);

  // Per-slot byte matches for each organization.
  logic [7:0] m32;
  logic [7:0] m16;
  logic [7:0] m8;
  for (genvar n = 0; n < 8; n++)
  begin : g_slot
    assign m32[n] = byte_match(code_reg[n], mask_reg[n], i_rx_msg.id_bytes[n % 4]);
    assign m16[n] = byte_match(code_reg[n], mask_reg[n], i_rx_msg.id_bytes[n % 2]);
    assign m8[n] = byte_match(code_reg[n], mask_reg[n], i_rx_msg.id_bytes[0]);
  end

  // Filter hit vectors; standard frames skip the second pair of a 32-bit bank.
  wire logic ext = i_rx_msg.ext;
  wire logic f32_0 = m32[0] & m32[1] & (~ext | (m32[2] & m32[3]));
  wire logic f32_1 = m32[4] & m32[5] & (~ext | (m32[6] & m32[7]));
  wire logic [7:0] hit32 = {6'h00, f32_1, f32_0};
  wire logic [7:0] hit16 = {4'h0, m16[7] & m16[6], m16[5] & m16[4],
                            m16[3] & m16[2], m16[1] & m16[0]};
  wire logic [7:0] hit_vec = (org_reg == CAF_ORG_32) ? hit32 :
                             (org_reg == CAF_ORG_16) ? hit16 :
                             (org_reg == CAF_ORG_8) ? m8 : 8'h00;
  wire logic accept = i_rx_valid & (|hit_vec);
  wire logic [2:0] hit_idx = first_hit(hit_vec);

  // Bus-off entry and hold flag; a new entry wins over a same-cycle clear.
  wire logic busoff_entry = i_busoff & ~busoff_q_reg;
  wire logic hold_set = busoff_entry & ctrl_reg[`CAF_CTRL_USER_RECOV];
  wire logic hold_clr = misc_wr & i_hwdata[`CAF_MISC_HOLD];
  wire logic hold_next = hold_set | (hold_reg & ~hold_clr);
  wire logic recover = hold_reg & hold_clr & ~hold_set & i_busoff;

  // Sticky interrupt status; events win over write-one-to-clear.
  wire logic [`CAF_INT_W-1:0] int_evt = {hold_set, accept};
  wire logic [`CAF_INT_W-1:0] int_clr = istat_wr ? i_hwdata[`CAF_INT_W-1:0] : '0;
  wire logic [`CAF_INT_W-1:0] istat_next = int_evt | (istat_reg & ~int_clr);

  // Read data selection for the register index of the pending read.
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = `CAF_WORD_RST;
    if (!addr_ok_reg)
    begin
      rd_word = `CAF_WORD_RST;
    end
    else if (filt_area)
    begin
      rd_word[7:0] = idx_reg[`CAF_IDX_IS_MASK] ? mask_reg[slot] : code_reg[slot];
    end
    else
    begin
      unique case (idx_reg)
        `CAF_IDX_CTRL: rd_word[`CAF_CTRL_W-1:0] = ctrl_reg;
        `CAF_IDX_STAT:
        begin
          rd_word[`CAF_STAT_INIT_ACK] = i_init_ack;
          rd_word[`CAF_STAT_SLEEP_ACK] = i_sleep_ack;
          rd_word[`CAF_STAT_BUSOFF] = i_busoff;
        end
        `CAF_IDX_FILT:
        begin
          rd_word[`CAF_FILT_ORG_MSB:`CAF_FILT_ORG_LSB] = org_reg;
          rd_word[`CAF_FILT_HIT_MSB:`CAF_FILT_HIT_LSB] = o_filter_hit_index;
        end
        `CAF_IDX_MISC: rd_word[`CAF_MISC_HOLD] = hold_reg;
        `CAF_IDX_RXERR: rd_word[7:0] = i_rx_err_cnt;
        `CAF_IDX_TXERR: rd_word[7:0] = i_tx_err_cnt;
        `CAF_IDX_ISTAT: rd_word[`CAF_INT_W-1:0] = istat_reg;
        `CAF_IDX_IMASK: rd_word[`CAF_INT_W-1:0] = imask_reg;
        `CAF_IDX_FGID: rd_word = fg_id_reg;
        `CAF_IDX_BGID: rd_word = bg_id_reg;
        default: rd_word = `CAF_WORD_RST;
      endcase
    end
  end

  // Bus slave: writes take no wait state, reads one wait state.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      bus_reg <= CAF_BUS_IDLE;
      idx_reg <= 6'h00;
      addr_ok_reg <= 1'b0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= `CAF_WORD_RST;
    end
    else if (bus_reg == CAF_BUS_READ)
    begin
      bus_reg <= CAF_BUS_IDLE;
      o_hrdata <= rd_word;
      o_hreadyout <= 1'b1;
    end
    else
    begin
      bus_reg <= take ? (i_hwrite ? CAF_BUS_WRITE : CAF_BUS_READ) : CAF_BUS_IDLE;
      idx_reg <= take ? i_haddr[`CAF_IDX_MSB:`CAF_IDX_LSB] : idx_reg;
      addr_ok_reg <= take ? addr_ok : addr_ok_reg;
      o_hreadyout <= ~(take & ~i_hwrite);
    end
  end

  // Acceptance code and mask storage, cleared at reset, loaded in init mode.
  always_ff @(posedge i_mclk)
  begin
    for (int n = 0; n < 8; n++)
    begin
      if (i_sys_rst)
      begin
        code_reg[n] <= `CAF_BYTE_RST;
        mask_reg[n] <= `CAF_BYTE_RST;
      end
      else
      begin
        if (code_wr && (slot == 3'(n)))
        begin
          code_reg[n] <= i_hwdata[7:0];
        end
        if (mask_wr && (slot == 3'(n)))
        begin
          mask_reg[n] <= i_hwdata[7:0];
        end
      end
    end
  end

  // Control, organization, hold flag and interrupt registers.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      ctrl_reg <= `CAF_CTRL_RST;
      org_reg <= CAF_ORG_32;
      hold_reg <= 1'b0;
      busoff_q_reg <= 1'b0;
      istat_reg <= `CAF_INT_RST;
      imask_reg <= `CAF_INT_RST;
      o_irq <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_wr ? i_hwdata[`CAF_CTRL_W-1:0] : ctrl_reg;
      org_reg <= org_wr ? caf_org_t'(i_hwdata[`CAF_FILT_ORG_MSB:`CAF_FILT_ORG_LSB]) : org_reg;
      hold_reg <= hold_next;
      busoff_q_reg <= i_busoff;
      istat_reg <= istat_next;
      imask_reg <= imask_wr ? i_hwdata[`CAF_INT_W-1:0] : imask_reg;
      o_irq <= |(istat_next & imask_reg);
    end
  end

  // Receive buffers: background takes every header, foreground only accepted ones.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      bg_id_reg <= `CAF_WORD_RST;
      fg_id_reg <= `CAF_WORD_RST;
      o_filter_hit_index <= 3'h0;
      o_rx_accept <= 1'b0;
    end
    else
    begin
      bg_id_reg <= i_rx_valid ? i_rx_msg.id_bytes : bg_id_reg;
      fg_id_reg <= accept ? i_rx_msg.id_bytes : fg_id_reg;
      o_filter_hit_index <= accept ? hit_idx : o_filter_hit_index;
      o_rx_accept <= accept;
    end
  end

  // Mode requests and bus-off handshake towards the protocol engine.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_init_request <= 1'b0;
      o_sleep_request <= 1'b0;
      o_busoff_hold <= 1'b0;
      o_recover_req <= 1'b0;
    end
    else
    begin
      o_init_request <= ctrl_wr ? i_hwdata[`CAF_CTRL_INIT_REQ] : ctrl_reg[`CAF_CTRL_INIT_REQ];
      o_sleep_request <= ctrl_wr ? i_hwdata[`CAF_CTRL_SLEEP_REQ] : ctrl_reg[`CAF_CTRL_SLEEP_REQ];
      o_busoff_hold <= hold_next;
      o_recover_req <= recover;
    end
  end

endmodule

// *** dv/caf_filter_props.sv ***
/*
  Port-level properties of the acceptance filter.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module caf_filter_props
  import caf_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_rx_valid,
  input wire logic i_busoff,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic o_busoff_hold,
  input wire logic o_recover_req,
  input wire logic o_rx_accept,
  input wire logic [2:0] o_filter_hit_index
);
  logic wr_dp;
  logic [5:0] dp_idx;
  logic wr_misc;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // Tracks a mapped write in its data phase and the register it targets.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      wr_dp <= 1'b0;
    else if (i_hready)
    begin
      wr_dp <= i_hsel && i_htrans[1] && i_hwrite && (i_haddr[31:8] == 24'h0);
      dp_idx <= i_haddr[7:2];
    end
  end
  assign wr_misc = wr_dp && (dp_idx == 6'h03);
  // Bus answer, hold flag, recovery and receive relations.
  a_resp_okay: assert property (o_hresp == 1'b0) else $error("hresp not okay");
  a_read_wait: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite
    |=> !o_hreadyout ##1 o_hreadyout) else $error("read wait state wrong");
  a_rdata_hold: assert property (o_hreadyout |=> $stable(o_hrdata)) else $error("hrdata moved");
  a_hold_rise: assert property ($rose(o_busoff_hold) |-> $past(i_busoff) && !$past(i_busoff, 2))
    else $error("hold set without bus-off entry");
  a_hold_keep: assert property (o_busoff_hold && !wr_misc |=> o_busoff_hold)
    else $error("hold dropped by itself");
  a_hold_clear: assert property (wr_misc && i_hwdata[0] && o_busoff_hold && $past(i_busoff)
    |=> !o_busoff_hold) else $error("hold not cleared");
  a_recover_cause: assert property (o_recover_req |-> $past(wr_misc) && $past(o_busoff_hold))
    else $error("recovery without clear");
  a_accept_cause: assert property (o_rx_accept |-> $past(i_rx_valid))
    else $error("accept without message");
  a_hit_steady: assert property (!o_rx_accept |-> $stable(o_filter_hit_index))
    else $error("hit index moved");
endmodule

bind caf_filter caf_filter_props u_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hwdata(i_hwdata), .i_hready(i_hready), .i_rx_valid(i_rx_valid), .i_busoff(i_busoff),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
  .o_busoff_hold(o_busoff_hold), .o_recover_req(o_recover_req), .o_rx_accept(o_rx_accept),
  .o_filter_hit_index(o_filter_hit_index));

// *** dv/caf_engine_model.sv ***
/*
  Behavioural protocol engine: headers, bus-off level, error counters, acknowledges.
  Assumes the filter's clock; the bench drives it through its tasks.
*/
`timescale 1ns/10ps
module caf_engine_model
  import caf_pkg::*;
#(
  parameter int ACK_DLY = 3
)
(
  input wire logic i_mclk,
  input wire logic i_init_request,
  input wire logic i_sleep_request,
  output logic o_rx_valid,
  output caf_rx_msg_t o_rx_msg,
  output logic o_busoff,
  output logic [7:0] o_rx_err_cnt,
  output logic [7:0] o_tx_err_cnt,
  output logic o_init_ack,
  output logic o_sleep_ack
);
  int cnt = 0;
  // Idle levels from time zero.
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_msg = '0;
    o_busoff = 1'b0;
    o_rx_err_cnt = 8'h00;
    o_tx_err_cnt = 8'h00;
    o_init_ack = 1'b0;
    o_sleep_ack = 1'b0;
  end
  // The init acknowledge trails its request, as a slow engine's would.
  always @(posedge i_mclk)
  begin
    cnt <= (o_init_ack == i_init_request) ? 0 : cnt + 1;
    if (cnt >= ACK_DLY)
      o_init_ack <= i_init_request;
    o_sleep_ack <= i_sleep_request;
  end
  // One header pulse; the header lines then show the inverse, not the old value.
  task send(input caf_rx_msg_t m);
    @(posedge i_mclk);
    o_rx_valid <= 1'b1;
    o_rx_msg <= m;
    @(posedge i_mclk);
    o_rx_valid <= 1'b0;
    o_rx_msg <= ~m;
  endtask
  // Bus-off level and counter values.
  task status(input logic b, input logic [7:0] r, input logic [7:0] t);
    @(posedge i_mclk);
    o_busoff <= b;
    o_rx_err_cnt <= r;
    o_tx_err_cnt <= t;
  endtask
endmodule

// *** dv/caf_filter_tb.sv ***
/*
  Self-checking bench of the acceptance filter: bus master, receive traffic, read queue.
  Assumes the engine model and the property checker are compiled before it.
*/
`timescale 1ns/10ps
module caf_filter_tb
  import caf_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_dp = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q[$];
  logic [7:0] cd[8];
  int n_mismatch = 0;
  int n_checks = 0;
  wire logic hrdy, hresp, init_rq, slp_rq, hold, rec, acc, irq, rxv, bo, iak, sak;
  wire logic [31:0] hrdata;
  wire logic [2:0] hit;
  wire logic [7:0] rxe, txe;
  wire caf_rx_msg_t rxm;
  // Module clock.
  always #12.5 i_mclk = ~i_mclk;
  caf_engine_model eng (.i_mclk(i_mclk), .i_init_request(init_rq), .i_sleep_request(slp_rq),
    .o_rx_valid(rxv), .o_rx_msg(rxm), .o_busoff(bo), .o_rx_err_cnt(rxe), .o_tx_err_cnt(txe),
    .o_init_ack(iak), .o_sleep_ack(sak));
  caf_filter uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .i_rx_valid(rxv), .i_rx_msg(rxm),
    .i_busoff(bo), .i_rx_err_cnt(rxe), .i_tx_err_cnt(txe), .i_init_ack(iak), .i_sleep_ack(sak),
    .o_init_request(init_rq), .o_sleep_request(slp_rq), .o_busoff_hold(hold),
    .o_recover_req(rec), .o_rx_accept(acc), .o_filter_hit_index(hit), .o_irq(irq));
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bounded wait for the next edge with ready high, or for an acknowledge level.
  task wt(input logic ack, input logic v);
    int k;
    k = 0;
    if (!ack)
      @(posedge i_mclk);
    while ((ack ? iak !== v : hrdy !== 1'b1) && k < 50)
    begin
      k++;
      @(posedge i_mclk);
    end
    if (k == 50)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  // One single transfer; for a read, d is the expected data.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    wt(1'b0, 1'b0);
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= !w;
    if (!w)
      q.push_back(d);
    wt(1'b0, 1'b0);
    rd_dp <= 1'b0;
  endtask
  // One header; checks the accept pulse and, when accepted, the hit index.
  task rx(input logic x, input logic [31:0] id, input logic a, input logic [2:0] h);
    caf_rx_msg_t m;
    m.ext = x;
    m.id_bytes = id;
    eng.send(m);
    @(posedge i_mclk);
    chk("accept", {31'h0, a}, {31'h0, acc});
    if (a)
      chk("hit", {29'h0, h}, {29'h0, hit});
  endtask
  // Compares each completed read with the oldest expectation.
  always @(posedge i_mclk)
  begin
    if (rd_dp === 1'b1 && hrdy === 1'b1)
      chk("hrdata", q.pop_front(), hrdata);
  end
  // Main sequence.
  initial
  begin
    int n;
    logic [31:0] ca;
    logic [31:0] id;
    void'($urandom(93));
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    bus(1'b0, 32'h40, 32'h0);
    bus(1'b0, 32'h7c, 32'h0);
    bus(1'b0, 32'h28, 32'h0);
    wt(1'b1, 1'b1);
    for (n = 0; n < 8; n++)
    begin
      cd[n] = {n[2:0], 5'($urandom)};
      ca = 32'h40 + 32'(4 * n) + ((n > 3) ? 32'h10 : 32'h0);
      bus(1'b1, ca, {24'h0, cd[n]});
      bus(1'b1, ca + 32'h10, (n % 4 == 1) ? 32'h7 : 32'h0);
    end
    bus(1'b0, 32'h64, {24'h0, cd[5]});
    id = {cd[3], cd[2], cd[1], cd[0]};
    rx(1'b1, id, 1'b1, 3'd0);
    rx(1'b1, id ^ 32'h0000_0200, 1'b1, 3'd0);
    rx(1'b1, id ^ 32'h0001_0000, 1'b0, 3'd0);
    rx(1'b0, id ^ 32'h8001_0000, 1'b1, 3'd0);
    rx(1'b1, {cd[7], cd[6], cd[5], cd[4]}, 1'b1, 3'd1);
    bus(1'b1, 32'h08, 32'h10);
    rx(1'b1, {16'h0, cd[5], cd[4]}, 1'b1, 3'd2);
    bus(1'b1, 32'h08, 32'h20);
    rx(1'b1, {24'h0, cd[6]}, 1'b1, 3'd6);
    bus(1'b1, 32'h08, 32'h30);
    rx(1'b1, id, 1'b0, 3'd0);
    bus(1'b0, 32'h08, 32'h36);
    bus(1'b1, 32'h08, 32'h0);
    bus(1'b1, 32'h1c, 32'h1);
    bus(1'b1, 32'h18, 32'h3);
    bus(1'b0, 32'h18, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    rx(1'b1, id, 1'b1, 3'd0);
    @(posedge i_mclk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 32'h1c, 32'h0);
    rx(1'b1, id, 1'b1, 3'd0);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b1, 32'h00, 32'h4);
    wt(1'b1, 1'b0);
    bus(1'b1, 32'h40, 32'hff);
    bus(1'b0, 32'h40, {24'h0, cd[0]});
    id = $urandom;
    eng.status(1'b1, id[7:0], id[15:8]);
    bus(1'b0, 32'h0c, 32'h1);
    chk("hold", 32'h1, {31'h0, hold});
    bus(1'b1, 32'h0c, 32'h0);
    bus(1'b0, 32'h0c, 32'h1);
    bus(1'b1, 32'h0c, 32'h1);
    @(posedge i_mclk);
    chk("recover", 32'h1, {31'h0, rec});
    bus(1'b0, 32'h0c, 32'h0);
    chk("hold", 32'h0, {31'h0, hold});
    // Counters are read only with sleep requested and acknowledged.
    bus(1'b1, 32'h00, 32'h6);
    bus(1'b0, 32'h04, 32'h6);
    chk("sleep", 32'h1, {31'h0, slp_rq});
    bus(1'b0, 32'h10, {24'h0, id[7:0]});
    bus(1'b1, 32'h14, 32'h0);
    bus(1'b0, 32'h14, {24'h0, id[15:8]});
    print_verdict();
  end
endmodule
